// *** verilog/nvc_defs.svh ***
/*
 * Constants of the memory and checksum command executor: command codes,
 * address limits, block sizes, checksum polynomials and program time.
 * Assumes the 10 MHz core clock.
 */
`ifndef NVC_DEFS_SVH
`define NVC_DEFS_SVH

`define NVC_CMD_IDLE 8'h00
`define NVC_CMD_PROGRAM 8'h01
`define NVC_CMD_FETCH 8'h03
`define NVC_CMD_PRELOAD 8'h07
`define NVC_CMD_CHECKSUM 8'h12
`define NVC_ADDR_MASK 16'h01FF
`define NVC_BLOCK0_LAST 9'h00F
`define NVC_KEY_FIRST 9'h080
`define NVC_KEY_LAST 9'h1FF
`define NVC_BOOT_ADDR 9'h010
`define NVC_PRELOAD_LEN 6'h20
`define NVC_PRELOAD_REG0 6'h10
`define NVC_BLOCK_BYTES 5'h10
`define NVC_PROG_TIME_NS 5800000
`define NVC_CLK_PERIOD_NS 100
`define NVC_PROG_CYCLES (`NVC_PROG_TIME_NS / `NVC_CLK_PERIOD_NS)
`define NVC_POLY8 8'h1D
`define NVC_POLY16 16'h1021
`define NVC_POLY16_REF 16'h8408

`endif

// *** verilog/nvc_pkg.sv ***
/*
 * Types of the memory and checksum command executor.
 * Assumes nvc_defs.svh for the numeric constants.
 */
package nvc_pkg;
   typedef enum logic [2:0] {
      NVC_IDLE, NVC_ARGS, NVC_PROG, NVC_FETCH, NVC_PRELOAD, NVC_CHECK
   } nvc_state_t;

   typedef struct packed {
      logic nvm_done_flag;
      logic checksum_done_flag;
      logic transmit_irq_flag;
      logic summary_error;
      logic forbidden_area_error;
      logic checksum_mismatch_error;
   } nvc_status_t;

   typedef struct packed {
      logic we;
      logic [8:0] addr;
      logic [7:0] wdata;
   } nvc_mem_req_t;
endpackage

// *** verilog/nvc_exec.sv ***
/*
 * Command executor for the nonvolatile memory and the checksum unit.
 * Holds the 512-byte memory array, the 16-byte staging buffer, the
 * program timer and the checksum engine.
 * Assumes a FIFO outside: fifo_empty_in/fifo_data_in show its head,
 * fifo_pop_out takes it, fifo_push_out stores fifo_wdata_out.
 */
// What this block does
// - Program: two address bytes, then data bytes.
// - Program ends only on a new host command after done.
// - Program cycle: one to sixteen bytes, 5.8ms.
// - Stage sixteen bytes; launch on full/empty.
// - Done flag low while busy; irq on rise.
// - Further bytes continue at next address.
// - Block zero writes flag error, no programming.
// - Start addresses reduced modulo 200h.
// - Fetch: address, count; copy to FIFO, stop.
// - Fetch from key area flags error.
// - Preload copies 32 bytes to registers 10h-2Fh.
// - Power-up preload from fixed address 10h.
// - Preload start not range-checked; key area flags error.
// - Checksum consumes all FIFO bytes, no output.
// - Checksum runs until idle; waits when empty.
// - Eight-bit polynomial x8+x4+x3+x2+1.
// - Sixteen-bit polynomial x16+x12+x5+1.
// - All bytes processed sets done and irq.
// - Commands start from host writes; reset starts the power-up preload.
// - Any error sets summary error bit.
`include "nvc_defs.svh"

module nvc_exec
   import nvc_pkg::*;
#(
   parameter int PROG_CYCLES = `NVC_PROG_CYCLES
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // Host command register
   input wire logic cmd_wr_in,
   input wire logic [7:0] cmd_in,
   // Checksum settings
   input wire logic checksum_width_select_in,
   input wire logic checksum_algorithm_select_in,
   input wire logic [7:0] checksum_preset_low_in,
   input wire logic [7:0] checksum_preset_high_in,
   // FIFO side
   input wire logic fifo_empty_in,
   input wire logic [7:0] fifo_data_in,
   output logic fifo_pop_out,
   output logic fifo_push_out,
   output logic [7:0] fifo_wdata_out,
   // Register preload port
   output logic cfg_we_out,
   output logic [5:0] cfg_addr_out,
   output logic [7:0] cfg_data_out,
   // Status and results
   output logic [7:0] active_cmd_out,
   output nvc_status_t status_out,
   output logic [7:0] checksum_result_low_out,
   output logic [7:0] checksum_result_high_out
);

   ////////////////////////////////////////////////////////////////////////
   nvc_state_t state;
   logic [7:0] cmd;
   logic [1:0] argn;
   logic [15:0] addr_arg;
   logic [8:0] addr;
   logic [7:0] count;
   logic [5:0] pre_idx;
   logic boot;
   logic [7:0] mem [0:511];
   logic [7:0] stage [0:15];
   logic [8:0] stage_base;
   logic [4:0] stage_n;
   logic [31:0] prog_cnt;
   logic [15:0] crc;
   logic nvm_done;
   logic crc_done;
   logic irq;
   logic acc_err;
   logic crc_err;
   logic launch;

   function automatic logic in_keys(input logic [8:0] a);
      in_keys = (a >= `NVC_KEY_FIRST) && (a <= `NVC_KEY_LAST);
   endfunction

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d,
                                            input logic w8, input logic alg);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (w8) begin
            // Eight-bit register, msb first
            r[7:0] = (r[7] ^ d[7-i]) ? ((r[7:0] << 1) ^ `NVC_POLY8) : (r[7:0] << 1);
            r[15:8] = 8'h00;
         end else if (alg) begin
            r = (r[15] ^ d[7-i]) ? ((r << 1) ^ `NVC_POLY16) : (r << 1);
         end else begin
            // Contactless style, lsb first, reflected polynomial
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ `NVC_POLY16_REF) : (r >> 1);
         end
      end
      crc_byte = r;
   endfunction

   wire logic stage_full = (stage_n == `NVC_BLOCK_BYTES);
   wire logic host_cmd = cmd_wr_in;
   // Idle is refused while a program cycle runs or bytes remain
   wire logic cmd_ok = host_cmd && !(state == NVC_PROG && !nvm_done);
   // No byte is taken in the launch cycle, where the staging buffer is flushed
   wire logic take = (state == NVC_ARGS || (state == NVC_PROG && prog_cnt == 32'h0)
                      || state == NVC_CHECK) && !fifo_empty_in && !cmd_ok && !launch;
   wire logic [8:0] addr_mod = addr_arg[8:0];

   ////////////////////////////////////////////////////////////////////////
   // Command sequencer, launched from host writes and, for the power-up preload, from reset
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         state <= NVC_PRELOAD;
         cmd <= `NVC_CMD_IDLE;
         argn <= 2'h0;
         addr_arg <= 16'h0000;
         addr <= `NVC_BOOT_ADDR;
         count <= 8'h00;
         pre_idx <= 6'h00;
         boot <= 1'b1;
      end else if (cmd_ok) begin
         cmd <= cmd_in;
         argn <= 2'h0;
         boot <= 1'b0;
         unique case (cmd_in)
            `NVC_CMD_PROGRAM, `NVC_CMD_FETCH, `NVC_CMD_PRELOAD: state <= NVC_ARGS;
            `NVC_CMD_CHECKSUM: state <= NVC_CHECK;
            default: state <= NVC_IDLE;
         endcase
      end else begin
         unique case (state)
            NVC_ARGS: if (take) begin
               argn <= argn + 2'h1;
               if (argn == 2'h0) begin
                  addr_arg[7:0] <= fifo_data_in;
               end else if (argn == 2'h1) begin
                  addr_arg[15:8] <= fifo_data_in;
                  if (cmd == `NVC_CMD_PROGRAM) begin
                     state <= NVC_PROG;
                     addr <= fifo_data_in[0] ? {1'b1, addr_arg[7:0]} : {1'b0, addr_arg[7:0]};
                  end else if (cmd == `NVC_CMD_PRELOAD) begin
                     state <= NVC_PRELOAD;
                     addr <= {fifo_data_in[0], addr_arg[7:0]};
                     pre_idx <= 6'h00;
                  end
               end else begin
                  count <= fifo_data_in;
                  addr <= addr_mod;
                  state <= NVC_FETCH;
               end
            end
            NVC_FETCH: begin
               if (count == 8'h00) begin
                  state <= NVC_IDLE;
                  cmd <= `NVC_CMD_IDLE;
               end else begin
                  count <= count - 8'h01;
                  addr <= addr + 9'h001;
               end
            end
            NVC_PRELOAD: begin
               addr <= addr + 9'h001;
               pre_idx <= pre_idx + 6'h01;
               if (pre_idx == `NVC_PRELOAD_LEN - 6'h01) begin
                  state <= NVC_IDLE;
                  cmd <= `NVC_CMD_IDLE;
                  boot <= 1'b0;
               end
            end
            NVC_PROG: if (take) begin
               addr <= addr + 9'h001;
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Staging buffer and program timer
   always_comb begin
      // Launch when the block's last slot fills or the FIFO runs dry
      launch = (state == NVC_PROG) && prog_cnt == 32'h0 && stage_n != 5'h00 &&
               (stage_full || fifo_empty_in);
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || cmd_ok) begin
         stage_n <= 5'h00;
         stage_base <= 9'h000;
         prog_cnt <= 32'h0;
      end else if (launch) begin
         stage_n <= 5'h00;
         // Block zero is never programmed
         if (stage_base > `NVC_BLOCK0_LAST) begin
            prog_cnt <= PROG_CYCLES;
            for (int i = 0; i < 16; i++) begin
               if (5'(i) < stage_n) begin
                  mem[9'(stage_base + 9'(i))] <= stage[i];
               end
            end
         end
      end else begin
         if (prog_cnt != 32'h0) begin
            prog_cnt <= prog_cnt - 32'h1;
         end
         if (state == NVC_PROG && take) begin
            if (stage_n == 5'h00) begin
               stage_base <= addr;
            end
            stage[stage_n[3:0]] <= fifo_data_in;
            // A block boundary closes the staging window early
            stage_n <= (addr[3:0] == 4'hF) ? `NVC_BLOCK_BYTES : stage_n + 5'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checksum engine
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         crc <= 16'h0000;
      end else if (cmd_ok && cmd_in == `NVC_CMD_CHECKSUM) begin
         crc <= {checksum_preset_high_in, checksum_preset_low_in};
      end else if (state == NVC_CHECK && take) begin
         crc <= crc_byte(crc, fifo_data_in, checksum_width_select_in,
                         checksum_algorithm_select_in);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flags
   wire logic nvm_idle = (state == NVC_PROG) && fifo_empty_in && stage_n == 5'h00 &&
                        prog_cnt == 32'h0;
   wire logic crc_idle = (state == NVC_CHECK) && fifo_empty_in;
   wire logic acc_set = (state == NVC_PROG && launch && stage_base <= `NVC_BLOCK0_LAST)
                        || (state == NVC_FETCH && count != 8'h00 && in_keys(addr))
                        || (state == NVC_PRELOAD && !boot && in_keys(addr));

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         nvm_done <= 1'b0;
         crc_done <= 1'b0;
         irq <= 1'b0;
         acc_err <= 1'b0;
         crc_err <= 1'b0;
      end else begin
         nvm_done <= nvm_idle;
         crc_done <= crc_idle && !take;
         // Events win over a new command clearing the flags
         irq <= (nvm_idle && !nvm_done) || (crc_idle && !crc_done) ||
                (irq && !cmd_ok);
         acc_err <= acc_set || (acc_err && !cmd_ok);
         crc_err <= (crc != 16'h0000);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   always_comb begin
      fifo_pop_out = take;
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         fifo_push_out <= 1'b0;
         fifo_wdata_out <= 8'h00;
         cfg_we_out <= 1'b0;
         cfg_addr_out <= 6'h00;
         cfg_data_out <= 8'h00;
      end else begin
         fifo_push_out <= (state == NVC_FETCH) && count != 8'h00 && !cmd_ok;
         fifo_wdata_out <= mem[addr];
         cfg_we_out <= (state == NVC_PRELOAD) && !cmd_ok;
         cfg_addr_out <= `NVC_PRELOAD_REG0 + pre_idx;
         cfg_data_out <= mem[addr];
      end
   end

   assign active_cmd_out = cmd;
   assign checksum_result_low_out = crc[7:0];
   assign checksum_result_high_out = crc[15:8];
   always_comb begin
      status_out.nvm_done_flag = nvm_done;
      status_out.checksum_done_flag = crc_done;
      status_out.transmit_irq_flag = irq;
      status_out.summary_error = acc_err || crc_err;
      status_out.forbidden_area_error = acc_err;
      status_out.checksum_mismatch_error = crc_err;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_done_irq_rise: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      $rose(nvm_done) |-> irq) else $error("irq missing on done");
   a_block0_guard: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      (launch && stage_base <= `NVC_BLOCK0_LAST) |=> (prog_cnt == 32'h0 && acc_err))
      else $error("block zero programmed");
   a_prog_time: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      (launch && stage_base > `NVC_BLOCK0_LAST && !cmd_ok) |=> prog_cnt == PROG_CYCLES)
      else $error("program time wrong");
   a_no_abort: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      (state == NVC_PROG && prog_cnt != 32'h0) |=> state == NVC_PROG)
      else $error("program aborted");
   a_stage_max: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      stage_n <= `NVC_BLOCK_BYTES) else $error("stage overflow");
   a_crc_preset: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      (cmd_ok && cmd_in == `NVC_CMD_CHECKSUM) |=>
      crc == {$past(checksum_preset_high_in), $past(checksum_preset_low_in)})
      else $error("preset not loaded");
   a_crc_hold: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      (state == NVC_CHECK && fifo_empty_in && !cmd_ok) |=> $stable(crc))
      else $error("checksum moved while empty");
   a_preload_len: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      (cfg_we_out && cfg_addr_out == 6'h2F) |-> state != NVC_PRELOAD)
      else $error("preload overran");
   a_err_summary: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      acc_err |-> status_out.summary_error) else $error("summary missing");
endmodule

// *** sim/nvc_fifo_model.sv ***
/*
 * Host-side FIFO model for the command executor: show-ahead head byte,
 * host loads and reads, block pops and pushes.
 * Assumes one clock; all traffic is sampled on its rising edge.
 */
module nvc_fifo_model (
   // Clock
   input wire logic core_clk_in,
   // Host side
   input wire logic load_in,
   input wire logic [7:0] load_data_in,
   input wire logic rd_in,
   output logic [7:0] rd_data_out,
   // Block side
   input wire logic fifo_pop_in,
   input wire logic fifo_push_in,
   input wire logic [7:0] fifo_wdata_in,
   output logic fifo_empty_out,
   output logic [7:0] fifo_data_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] q[$];
   initial begin
      fifo_empty_out = 1'b1;
      fifo_data_out = 8'h00;
      rd_data_out = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Host loads arguments in the documented order
   always @(posedge core_clk_in) begin
      if ((fifo_pop_in || rd_in) && q.size() > 0) begin
         rd_data_out <= q[0];
         void'(q.pop_front());
      end
      if (fifo_push_in) q.push_back(fifo_wdata_in);
      if (load_in) q.push_back(load_data_in);
      fifo_empty_out <= (q.size() == 0);
      // An empty FIFO inverts its shown byte every cycle, so the stale byte returns every second cycle
      if (q.size() == 0) fifo_data_out <= ~fifo_data_out;
      else fifo_data_out <= q[0];
   end
endmodule

// *** sim/nvc_exec_tb.sv ***
/*
 * Self-checking bench for the command executor: program, fetch, preload
 * and checksum sequences through the host FIFO model.
 * Assumes a 10 MHz clock and a shortened program time.
 */
module nvc_exec_tb;
   import nvc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_in = 1'b0, rstn_in = 1'b0, cmd_wr_in = 1'b0, w8 = 1'b0, alg = 1'b0;
   logic load_in = 1'b0, rd_in = 1'b0;
   logic [7:0] cmd_in = 8'h00, pl = 8'h00, ph = 8'h00, load_data = 8'h00, b;
   logic fifo_empty, fifo_pop, fifo_push, cfg_we;
   logic [7:0] fifo_data, fifo_wdata, rd_data, cfg_data, active_cmd, res_lo, res_hi;
   logic [5:0] cfg_addr, cfg_first, cfg_last;
   logic [15:0] exp;
   nvc_status_t status;
   int err_total = 0, tests_run = 0, cfg_cnt = 0;
   logic [7:0] cfg_seen[64];
   nvc_exec #(.PROG_CYCLES(20)) u_nvc_exec (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
      .cmd_wr_in(cmd_wr_in), .cmd_in(cmd_in), .checksum_width_select_in(w8),
      .checksum_algorithm_select_in(alg), .checksum_preset_low_in(pl),
      .checksum_preset_high_in(ph), .fifo_empty_in(fifo_empty), .fifo_data_in(fifo_data),
      .fifo_pop_out(fifo_pop), .fifo_push_out(fifo_push), .fifo_wdata_out(fifo_wdata),
      .cfg_we_out(cfg_we), .cfg_addr_out(cfg_addr), .cfg_data_out(cfg_data),
      .active_cmd_out(active_cmd), .status_out(status), .checksum_result_low_out(res_lo),
      .checksum_result_high_out(res_hi));
   nvc_fifo_model u_nvc_fifo_model (.core_clk_in(core_clk_in), .load_in(load_in),
      .load_data_in(load_data), .rd_in(rd_in), .rd_data_out(rd_data),
      .fifo_pop_in(fifo_pop), .fifo_push_in(fifo_push), .fifo_wdata_in(fifo_wdata),
      .fifo_empty_out(fifo_empty), .fifo_data_out(fifo_data));
   initial begin
      forever #50 core_clk_in = ~core_clk_in;
   end
   always @(posedge core_clk_in) begin
      if (cfg_we === 1'b1) begin
         if (cfg_cnt == 0) cfg_first = cfg_addr;
         cfg_last = cfg_addr;
         cfg_seen[cfg_addr] = cfg_data;
         cfg_cnt++;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] want);
      tests_run++;
      if (got !== want) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask
   task automatic command(input logic [7:0] c);
      @(posedge core_clk_in);
      cmd_wr_in <= 1'b1;
      cmd_in <= c;
      @(posedge core_clk_in);
      cmd_wr_in <= 1'b0;
   endtask
   task automatic host_load(input logic [7:0] v);
      @(posedge core_clk_in);
      load_in <= 1'b1;
      load_data <= v;
      @(posedge core_clk_in);
      load_in <= 1'b0;
   endtask
   task automatic host_read(output logic [7:0] v);
      @(posedge core_clk_in);
      rd_in <= 1'b1;
      @(posedge core_clk_in);
      rd_in <= 1'b0;
      #1 v = rd_data;
   endtask
   // which: 0 program done, 1 checksum done, 2 back in idle
   task automatic wait_for(input int which);
      for (int n = 0; n < 3000; n++) begin
         @(posedge core_clk_in);
         #1;
         if (which == 0 && status.nvm_done_flag === 1'b1) return;
         if (which == 1 && status.checksum_done_flag === 1'b1) return;
         if (which == 2 && active_cmd === 8'h00) return;
      end
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, which, 0);
   endtask
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d,
                                            input logic m8, input logic hd);
      logic fb;
      for (int i = 0; i < 8; i++) begin
         if (m8) begin
            fb = c[7] ^ d[7-i];
            c = {8'h00, c[6:0], 1'b0} ^ (fb ? 16'h001D : 16'h0000);
         end else if (hd) begin
            fb = c[15] ^ d[7-i];
            c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
         end else begin
            fb = c[0] ^ d[i];
            c = (c >> 1) ^ (fb ? 16'h8408 : 16'h0000);
         end
      end
      return c;
   endfunction
   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      tick(5000);
      err_total++;
      print_verdict;
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(6);
      rstn_in <= 1'b1;
      tick(34);
      cmp8(cfg_cnt, 8'h20);
      cmp8(cfg_first, 6'h10);
      cmp8(cfg_last, 6'h2F);
      $display("test power-up preload done");
      // High byte 02h folds to start 02Ch; five bytes cross the block end
      host_load(8'h2C);
      host_load(8'h02);
      for (int i = 0; i < 5; i++) host_load(8'hA0 + i[7:0]);
      command(8'h01);
      wait_for(0);
      cmp8(status.transmit_irq_flag, 1'b1);
      cmp8(active_cmd, 8'h01);
      host_load(8'hB0);
      host_load(8'hB1);
      tick(2);
      cmp8(status.nvm_done_flag, 1'b0);
      wait_for(0);
      command(8'h00);
      wait_for(2);
      $display("test program done");
      host_load(8'h2C);
      host_load(8'h02);
      host_load(8'h07);
      command(8'h03);
      wait_for(2);
      tick(3);
      for (int i = 0; i < 7; i++) begin
         host_read(b);
         cmp8(b, i < 5 ? 8'hA0 + i[7:0] : 8'hAB + i[7:0]);
      end
      cmp8(status.forbidden_area_error, 1'b0);
      $display("test fetch done");
      cfg_cnt = 0;
      host_load(8'h2C);
      host_load(8'h00);
      command(8'h07);
      wait_for(2);
      tick(2);
      cmp8(cfg_cnt, 8'h20);
      cmp8(cfg_first, 6'h10);
      cmp8(cfg_last, 6'h2F);
      cmp8(cfg_seen[6'h10], 8'hA0);
      cmp8(cfg_seen[6'h15], 8'hB0);
      $display("test preload done");
      for (int m = 0; m < 3; m++) begin
         w8 <= (m == 0);
         alg <= (m == 1);
         pl <= 8'h63;
         ph <= 8'hC6;
         exp = (m == 0) ? 16'h0063 : 16'hC663;
         for (int i = 0; i < 3; i++) begin
            host_load(8'h12 * (i[7:0] + 8'h01));
            exp = crc_byte(exp, 8'h12 * (i[7:0] + 8'h01), m == 0, m == 1);
         end
         command(8'h12);
         wait_for(1);
         cmp8(status.transmit_irq_flag, 1'b1);
         cmp8(res_lo, exp[7:0]);
         cmp8(res_hi, exp[15:8]);
         cmp8(status.checksum_mismatch_error, exp != 16'h0000);
         cmp8(active_cmd, 8'h12);
         command(8'h00);
         wait_for(2);
      end
      $display("test checksum done");
      host_load(8'h80);
      host_load(8'h00);
      host_load(8'h01);
      command(8'h03);
      wait_for(2);
      tick(3);
      host_read(b);
      cmp8(status.forbidden_area_error, 1'b1);
      cmp8(status.summary_error, 1'b1);
      host_load(8'h05);
      host_load(8'h00);
      host_load(8'h5A);
      command(8'h01);
      tick(10);
      cmp8(status.forbidden_area_error, 1'b1);
      $display("test access errors done");
      print_verdict;
   end
endmodule
